// ### src/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_STORE_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h01;
    localparam logic [7:0] OFS_STATUS = 8'h02;
    localparam logic [7:0] OFS_CACHE_CTRL = 8'h03;

    // Field positions.
    localparam int WE_BIT = 0;
    localparam int EE_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int OPEN_BIT = 1;
    localparam int DEAD_BIT = 2;
    localparam int BLKW_BIT = 0;

    // Reset values.
    localparam logic [1:0] STORE_CTRL_RST = 2'h0;
    localparam logic BLKW_RST = 1'b0;

    // Key codes and flash geometry.
    localparam logic [7:0] KEY_FIRST_CODE = 8'hA5;
    localparam logic [7:0] KEY_SECOND_CODE = 8'hF1;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] USER_TOP = 16'h7BFF;
    localparam int FLASH_BYTES = 32768;
    localparam int PAGE_BYTES = 1024;

    // Timing at the 20 MHz system clock.
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 20000;
    localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] WRITE_LAST = 10'(WRITE_CYC - 1);
    localparam logic [9:0] ERASE_LAST = 10'(PAGE_BYTES - 1);

    typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} key_state_t;
    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} op_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } xmove_t;

endpackage

// ### src/flash_program_erase_control.sv
// Notes on behaviour
// - Write enable steers data-move writes to flash.
// - Write enable cleared only by software.
// - Data-move reads always go to external RAM.
// - Flash contents read through code-space reads.
// - Programming only clears bits: old AND new.
// - Busy flag reads one during operations.
// - Core stalls on flash fetch while busy.
// - Interrupts stay pending until operation ends.
// - Monitor off: no operation, flash error reset.
// - Key register needs A5 then F1.
// - Bad key order locks flash until reset.
// - Unkeyed attempt locks flash until reset.
// - Each operation relocks the key.
// - Erase needs both enables and key.
// - Erase sets whole 1024-byte page to FF.
// - Any write into page starts its erase.
// - Block select picks byte or four-byte writes.
// - Block write takes single-byte programming time.
// - Byte mode programs after every flash write.
// - Block bytes ascend; program after 11b.
// - Target above user space gives error reset.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_control
    import flash_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire xmove_t xReq,
    output xmove_t xramReq,
    input wire logic codeRd,
    input wire logic [14:0] codeAddr,
    output logic [7:0] codeRdata,
    input wire logic fetchReq,
    input wire logic [14:0] fetchAddr,
    output logic [7:0] fetchRdata,
    output logic coreStall,
    input wire logic vddMonOn,
    input wire logic [3:0] irqReq,
    input wire logic [3:0] irqAck,
    output logic [3:0] irqGrant,
    output logic flashBusy,
    output logic flashErrRst
);

    localparam int PROG_HOLD = WRITE_CYC;

    logic [7:0] mem [0:FLASH_BYTES-1];

    logic storeWe;
    logic storeEe;
    logic blkSel;
    key_state_t keyState;
    op_state_t opState;
    op_state_t next_opState;
    logic [9:0] cnt;
    logic [4:0] opPage;
    logic vddSync1;
    logic vddOk;
    logic [1:0] blkIdx;
    logic [23:0] blkBuf;
    logic [3:0] irqPend;

    logic flashHit;
    logic keyOk;
    logic addrBad;
    logic attemptOk;
    logic eraseStart;
    logic progStart;
    logic blkByte;
    logic opDone;
    logic busyNext;
    logic [3:0] progMask;
    logic [31:0] progData;
    logic [12:0] progWord;
    logic [3:0] pendLeft;

    // The monitor enable comes from another domain.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vddSync1 <= 1'b0;
            vddOk <= 1'b0;
        end
        else
        begin
            vddSync1 <= vddMonOn;
            vddOk <= vddSync1;
        end
    end

    // Data-move writes during an operation are dropped, not queued.
    assign flashHit = xReq.wr && storeWe && (opState == OP_IDLE);
    assign keyOk = (keyState == KEY_OPEN);
    assign addrBad = (xReq.addr > USER_TOP);
    assign attemptOk = flashHit && keyOk && vddOk && !addrBad;
    assign eraseStart = attemptOk && storeEe;
    assign blkByte = attemptOk && !storeEe && blkSel;
    assign progStart = attemptOk && !storeEe && (!blkSel || (xReq.addr[1:0] == 2'h3 && blkIdx == 2'h3));

    always_comb
    begin
        progWord = xReq.addr[14:2];
        if (blkSel)
        begin
            progMask = 4'hF;
            progData = {xReq.data, blkBuf};
        end
        else
        begin
            progMask = 4'h1 << xReq.addr[1:0];
            progData = {4{xReq.data}};
        end
    end

    assign opDone = (opState == OP_PROG && cnt == WRITE_LAST) || (opState == OP_ERASE && cnt == ERASE_LAST);

    always_comb
    begin
        next_opState = opState;
        case (opState)
            OP_IDLE:
            begin
                if (eraseStart)
                    next_opState = OP_ERASE;
                else if (progStart)
                    next_opState = OP_PROG;
            end
            OP_PROG, OP_ERASE:
            begin
                if (opDone)
                    next_opState = OP_IDLE;
            end
            default:
                next_opState = OP_IDLE;
        endcase
    end

    assign busyNext = (next_opState != OP_IDLE);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opState <= OP_IDLE;
            cnt <= 10'h000;
            opPage <= 5'h00;
        end
        else
        begin
            opState <= next_opState;
            // Block and byte writes share one timer.
            if (opState == OP_IDLE || opDone)
                cnt <= 10'h000;
            else
                cnt <= cnt + 10'h001;
            if (eraseStart)
                opPage <= xReq.addr[14:10];
        end
    end

    // Enables change only by software writes.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            storeWe <= STORE_CTRL_RST[WE_BIT];
            storeEe <= STORE_CTRL_RST[EE_BIT];
            blkSel <= BLKW_RST;
        end
        else if (regWr)
        begin
            if (regAddr == OFS_STORE_CTRL)
            begin
                storeWe <= regWdata[WE_BIT];
                storeEe <= regWdata[EE_BIT];
            end
            if (regAddr == OFS_CACHE_CTRL)
                blkSel <= regWdata[BLKW_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            keyState <= KEY_LOCKED;
        else if (keyState == KEY_DEAD)
            keyState <= KEY_DEAD;
        else if (flashHit)
            keyState <= keyOk ? KEY_LOCKED : KEY_DEAD;
        else if (regWr && regAddr == OFS_KEY)
        begin
            case (keyState)
                KEY_LOCKED:
                    keyState <= (regWdata == KEY_FIRST_CODE) ? KEY_HALF : KEY_DEAD;
                KEY_HALF:
                    keyState <= (regWdata == KEY_SECOND_CODE) ? KEY_OPEN : KEY_DEAD;
                default:
                    keyState <= KEY_DEAD;
            endcase
        end
    end

    // An out-of-order block byte abandons the block being gathered.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blkIdx <= 2'h0;
            blkBuf <= 24'h000000;
        end
        else if (blkByte)
        begin
            if (xReq.addr[1:0] == blkIdx)
            begin
                blkIdx <= blkIdx + 2'h1;
                if (blkIdx != 2'h3)
                    blkBuf[blkIdx*8 +: 8] <= xReq.data;
            end
            else
                blkIdx <= 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            flashErrRst <= 1'b0;
        else
            flashErrRst <= flashHit && keyOk && (!vddOk || addrBad);
    end

    always_ff @(posedge clk_sys)
    begin
        if (opState == OP_IDLE && progStart)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (progMask[i])
                    mem[{progWord, 2'(i)}] <= mem[{progWord, 2'(i)}] & progData[i*8 +: 8];
            end
        end
        // The erase walks the page one byte per cycle.
        if (opState == OP_ERASE)
            mem[{opPage, cnt}] <= ERASED_BYTE;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            codeRdata <= 8'h00;
            fetchRdata <= 8'h00;
        end
        else
        begin
            if (codeRd)
                codeRdata <= mem[codeAddr];
            if (fetchReq && !busyNext)
                fetchRdata <= mem[fetchAddr];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flashBusy <= 1'b0;
            coreStall <= 1'b0;
        end
        else
        begin
            flashBusy <= busyNext;
            coreStall <= busyNext && fetchReq;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            xramReq <= '0;
        else
        begin
            xramReq.wr <= xReq.wr && !storeWe;
            xramReq.rd <= xReq.rd;
            xramReq.addr <= xReq.addr;
            xramReq.data <= xReq.data;
        end
    end

    // A request arriving with its own acknowledge stays pending.
    assign pendLeft = (irqPend & ~irqAck) | irqReq;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqPend <= 4'h0;
            irqGrant <= 4'h0;
        end
        else
        begin
            irqPend <= pendLeft;
            // Lowest index is the highest priority.
            irqGrant <= busyNext ? 4'h0 : (pendLeft & (~pendLeft + 4'h1));
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            regRdata <= 8'h00;
        else if (regRd)
        begin
            case (regAddr)
                OFS_STORE_CTRL:
                    regRdata <= {6'h00, storeEe, storeWe};
                OFS_STATUS:
                    regRdata <= {5'h00, keyState == KEY_DEAD, keyOk, opState != OP_IDLE};
                OFS_CACHE_CTRL:
                    regRdata <= {7'h00, blkSel};
                default:
                    regRdata <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // The busy run is counted apart from the operation timer, so a timer fault cannot hide itself.
    logic [10:0] busyRun;
    logic runProg;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busyRun <= 11'h000;
            runProg <= 1'b0;
        end
        else
        begin
            busyRun <= flashBusy ? busyRun + 11'h001 : 11'h000;
            if (opState == OP_IDLE && (progStart || eraseStart))
                runProg <= !eraseStart;
        end
    end

    sequence s_busy_run;
        flashBusy [*8];
    endsequence

    sequence s_prog_end;
        $fell(flashBusy) && runProg;
    endsequence

    property p_external_data_ram_route;
        xReq.wr && !storeWe |=> xramReq.wr;
    endproperty
    a_external_data_ram_route: assert property (p_external_data_ram_route) else $error("ram write lost");

    property p_flash_route;
        xReq.wr && storeWe |=> !xramReq.wr;
    endproperty
    a_flash_route: assert property (p_flash_route) else $error("flash write hit ram");

    property p_read_ram;
        xReq.rd |=> xramReq.rd;
    endproperty
    a_read_ram: assert property (p_read_ram) else $error("ram read lost");

    property p_we_sticky;
        storeWe && !(regWr && regAddr == OFS_STORE_CTRL) |=> storeWe;
    endproperty
    a_we_sticky: assert property (p_we_sticky) else $error("write enable dropped");

    property p_busy_on;
        (progStart || eraseStart) && opState == OP_IDLE |=> s_busy_run;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy not shown");

    property p_prog_time;
        s_prog_end |-> busyRun == 11'(PROG_HOLD);
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("program time wrong");

    property p_stall_end;
        $fell(flashBusy) |-> !coreStall && !$past(flashBusy, 2) == 1'b0;
    endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall outlived busy");

    property p_stall_busy;
        coreStall |-> flashBusy;
    endproperty
    a_stall_busy: assert property (p_stall_busy) else $error("stall while idle");

    property p_key_dead;
        keyState == KEY_DEAD |=> (keyState == KEY_DEAD && !$rose(flashBusy)) [*2];
    endproperty
    a_key_dead: assert property (p_key_dead) else $error("dead key revived");

    property p_relock;
        attemptOk |=> keyState == KEY_LOCKED;
    endproperty
    a_relock: assert property (p_relock) else $error("key not relocked");

    property p_vdd_err;
        flashHit && keyOk && !vddOk |=> flashErrRst && !flashBusy;
    endproperty
    a_vdd_err: assert property (p_vdd_err) else $error("monitor off not caught");

    property p_erase_gate;
        $rose(flashBusy) && !runProg |-> $past(storeEe) && $past(storeWe) && $past(keyOk);
    endproperty
    a_erase_gate: assert property (p_erase_gate) else $error("erase without enables");

    property p_irq_hold;
        flashBusy |-> irqGrant == 4'h0;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt during busy");

endmodule

`default_nettype wire

// ### sim/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Core side: data moves and code reads are held for exactly one taking edge, then released; a fetch request holds until the next fetch call.
module core_model
    import flash_ctrl_pkg::*;
(
    input wire logic clk_sys,
    output var xmove_t xReq,
    output logic codeRd,
    output logic [14:0] codeAddr,
    output logic fetchReq,
    output logic [14:0] fetchAddr
);
    initial
    begin
        xReq = '0;
        codeRd = 1'b0;
        codeAddr = '0;
        fetchReq = 1'b0;
        fetchAddr = '0;
    end

    // Released fields are inverted so a stale address or byte is never taken for a live one.
    task automatic move(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        xReq <= '{wr, ~wr, a, d};
        @(posedge clk_sys);
        xReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic codeRead(input logic [14:0] a);
        @(posedge clk_sys);
        codeRd <= 1'b1;
        codeAddr <= a;
        @(posedge clk_sys);
        codeRd <= 1'b0;
        codeAddr <= ~a;
    endtask

    task automatic fetch(input logic on, input logic [14:0] a);
        fetchReq <= on;
        fetchAddr <= a;
    endtask
endmodule

`default_nettype wire

// ### sim/flash_program_erase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end

module flash_program_erase_control_test
    import flash_ctrl_pkg::*;
();
    logic clk_sys = 1'b0;
    logic arst_n;
    logic [7:0] regAddr, regWdata, regRdata;
    logic regWr, regRd, codeRd, fetchReq, coreStall, vddMonOn, flashBusy, flashErrRst;
    logic [14:0] codeAddr, fetchAddr;
    logic [7:0] codeRdata, fetchRdata;
    logic [3:0] irqReq, irqAck, irqGrant;
    xmove_t xReq, xramReq, popX;
    logic [7:0] expB[$];
    xmove_t expX[$];
    int expN[$];
    logic [7:0] popB;
    int popN;
    int busyCnt = 0;
    int errCnt = 0;
    int err_total = 0;
    int checked = 0;
    logic [1:0] rdTag = 2'b00;
    logic busyPrev = 1'b0;
    logic [7:0] seed = 8'h33;
    logic [7:0] db[4];

    always #25 clk_sys = ~clk_sys;

    flash_program_erase_control i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .xReq(xReq),
        .xramReq(xramReq), .codeRd(codeRd), .codeAddr(codeAddr), .codeRdata(codeRdata),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchRdata(fetchRdata), .coreStall(coreStall),
        .vddMonOn(vddMonOn), .irqReq(irqReq), .irqAck(irqAck), .irqGrant(irqGrant),
        .flashBusy(flashBusy), .flashErrRst(flashErrRst));

    core_model i_core (.clk_sys(clk_sys), .xReq(xReq), .codeRd(codeRd), .codeAddr(codeAddr),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr));

    // Results are matched against the oldest note in the queue of their kind.
    always @(posedge clk_sys)
    begin
        rdTag <= {codeRd, regRd};
        busyPrev <= flashBusy;
        if (flashBusy === 1'b1)
            busyCnt <= busyCnt + 1;
        if (flashErrRst === 1'b1)
            errCnt <= errCnt + 1;
        if (rdTag != 2'b00)
        begin
            popB = expB.pop_front();
            `CHK(rdTag[1] ? codeRdata : regRdata, popB)
        end
        if (xramReq.wr === 1'b1 || xramReq.rd === 1'b1)
        begin
            popX = expX.pop_front();
            `CHK(xramReq, popX)
        end
        if (busyPrev === 1'b1 && flashBusy === 1'b0)
        begin
            popN = expN.pop_front();
            `CHK(busyCnt, popN)
            `CHK(coreStall, 1'b0)
            busyCnt <= 0;
        end
        if (flashBusy === 1'b1)
            `CHK(irqGrant, 4'h0)
    end

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic regW(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic regR(input logic [7:0] a, input logic [7:0] e);
        expB.push_back(e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask

    task automatic unlock();
        regW(OFS_KEY, KEY_FIRST_CODE);
        regW(OFS_KEY, KEY_SECOND_CODE);
    endtask

    task automatic codeChk(input logic [14:0] a, input logic [7:0] e);
        expB.push_back(e);
        i_core.codeRead(a);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (flashBusy !== 1'b0 && n < 2000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000)
        begin
            err_total++;
            complete_run();
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        tick(10000);
        err_total++;
        complete_run();
    end

    initial
    begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        irqReq = 4'h0;
        irqAck = 4'h0;
        vddMonOn = 1'b1;
        arst_n = 1'b0;
        tick(6);
        arst_n <= 1'b1;
        tick(3);
        regR(OFS_STORE_CTRL, 8'h00);
        regR(OFS_STATUS, 8'h00);
        regR(OFS_CACHE_CTRL, 8'h00);
        regR(OFS_KEY, 8'h00);
        regR(8'h7E, 8'h00);
        expX.push_back('{1'b1, 1'b0, 16'h0455, 8'h3C});
        i_core.move(1'b1, 16'h0455, 8'h3C);
        regW(OFS_STORE_CTRL, 8'h01);
        expX.push_back('{1'b0, 1'b1, 16'h1234, 8'h00});
        i_core.move(1'b0, 16'h1234, 8'h00);
        tick(20);
        regR(OFS_STORE_CTRL, 8'h01);
        regW(OFS_STORE_CTRL, 8'h00);
        done("routing");
        unlock();
        regR(OFS_STATUS, 8'h02);
        regW(OFS_STORE_CTRL, 8'h02);
        regW(OFS_STORE_CTRL, 8'h03);
        expN.push_back(PAGE_BYTES);
        i_core.move(1'b1, 16'h0500, rnd());
        regR(OFS_STATUS, 8'h01);
        i_core.fetch(1'b1, 15'h0100);
        irqReq <= 4'hC;
        tick(1);
        irqReq <= 4'h0;
        tick(3);
        `CHK(coreStall, 1'b1)
        waitIdle();
        regW(OFS_STORE_CTRL, 8'h01);
        regW(OFS_STORE_CTRL, 8'h00);
        i_core.fetch(1'b0, 15'h7EFF);
        tick(2);
        `CHK(irqGrant, 4'h4)
        irqAck <= 4'h4;
        tick(1);
        irqAck <= 4'h0;
        tick(2);
        `CHK(irqGrant, 4'h8)
        codeChk(15'h0400, ERASED_BYTE);
        codeChk(15'h07FF, ERASED_BYTE);
        done("erase");
        regW(OFS_CACHE_CTRL, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            db[i] = rnd();
            unlock();
            regW(OFS_STORE_CTRL, 8'h01);
            expN.push_back(WRITE_CYC);
            i_core.move(1'b1, 16'h0455, db[i]);
            waitIdle();
            regW(OFS_STORE_CTRL, 8'h00);
        end
        codeChk(15'h0455, db[0] & db[1]);
        done("byte");
        regW(OFS_CACHE_CTRL, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            db[i] = rnd();
            unlock();
            regW(OFS_STORE_CTRL, 8'h01);
            if (i == 3)
                expN.push_back(WRITE_CYC);
            i_core.move(1'b1, 16'h0460 + 16'(i), db[i]);
            regW(OFS_STORE_CTRL, 8'h00);
        end
        waitIdle();
        for (int i = 0; i < 4; i++)
            codeChk(15'h0460 + 15'(i), db[i]);
        unlock();
        regW(OFS_STORE_CTRL, 8'h01);
        i_core.move(1'b1, 16'h0467, 8'h00);
        regW(OFS_STORE_CTRL, 8'h00);
        codeChk(15'h0467, ERASED_BYTE);
        i_core.fetch(1'b1, 15'h0461);
        tick(1);
        i_core.fetch(1'b0, 15'h7EFF);
        tick(1);
        `CHK(fetchRdata, db[1])
        done("block");
        regW(OFS_CACHE_CTRL, 8'h00);
        vddMonOn <= 1'b0;
        tick(4);
        unlock();
        regW(OFS_STORE_CTRL, 8'h01);
        i_core.move(1'b1, 16'h0470, 8'h00);
        tick(3);
        `CHK(errCnt, 1)
        vddMonOn <= 1'b1;
        tick(4);
        regR(OFS_STATUS, 8'h00);
        unlock();
        i_core.move(1'b1, 16'h8000, 8'h00);
        tick(3);
        `CHK(errCnt, 2)
        regW(OFS_STORE_CTRL, 8'h00);
        codeChk(15'h0470, ERASED_BYTE);
        done("error reset");
        regW(OFS_STORE_CTRL, 8'h01);
        i_core.move(1'b1, 16'h0480, 8'h00);
        regR(OFS_STATUS, 8'h04);
        unlock();
        i_core.move(1'b1, 16'h0480, 8'h00);
        tick(3);
        regW(OFS_STORE_CTRL, 8'h00);
        codeChk(15'h0480, ERASED_BYTE);
        tick(2);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(3);
        regR(OFS_STATUS, 8'h00);
        regW(OFS_KEY, KEY_SECOND_CODE);
        unlock();
        regR(OFS_STATUS, 8'h04);
        done("lockout");
        tick(2);
        `CHK(expB.size() + expX.size() + expN.size(), 0)
        complete_run();
    end
endmodule

`default_nettype wire
